//--- core/ptef_defines.svh
`ifndef PTEF_DEFINES_SVH
`define PTEF_DEFINES_SVH

// ------------------------------------------------------------
// Widths, buffer depth and reset values
// ------------------------------------------------------------
`define PTEF_DATA_W 8
`define PTEF_FLAG_RST 1'b0
`define PTEF_BUF_DEPTH 2

`endif

//--- core/ptef_pkg.sv
`include "ptef_defines.svh"

package ptef_pkg;
	typedef logic [`PTEF_DATA_W-1:0] ptef_byte_t;
	typedef enum logic [3:0] {
		PTEF_ISOLATE = 4'h1,
		PTEF_RECEIVE = 4'h2,
		PTEF_TRANSMIT = 4'h4,
		PTEF_FORCE = 4'h8
	} ptef_mode_t;
	typedef enum logic [2:0] {
		PTEF_REGISTERED = 3'h1,
		PTEF_LATCHED = 3'h2,
		PTEF_LATCHED_HOLD = 3'h4
	} ptef_variant_t;
endpackage

//--- core/ptef_transceiver.sv
// Behaviour
// RULE1 - Receive enable low alone selects receive
// RULE2 - Transmit enable low alone selects transmit
// RULE3 - Host port eight bits, bidirectional
// RULE4 - Bus port eight bits, bidirectional
// RULE5 - Transmit parity makes nine bits odd
// RULE6 - Receive checks bus plus parity odd
// RULE7 - Both enables high floats everything; fault_n_oe still follows the flag in isolation
// RULE8 - Both enables low forces parity error
// RULE9 - Fault flag low on parity mismatch
// RULE10 - Registered flag sticks until cleared
// RULE11 - Registered flag loads on clock edge
// RULE12 - Clear low empties registered flag
// RULE13 - Latched flag sticks until cleared
// RULE14 - Gate low: pass or sample
// RULE15 - Gate high, clear low: clear
// RULE16 - Gate high, clear high: store
// RULE17 - Hold variant keeps flag when isolated
// RULE18 - Fault output is open drain
// RULE19 - Controller keeps receive mode for flag ops
// RULE20 - Flag modelled as level plus enable
module ptef_transceiver
	import ptef_pkg::*;
#(
	parameter ptef_variant_t VARIANT = PTEF_REGISTERED
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic receive_drive_n,
	input wire logic transmit_drive_n,
	input wire logic flag_reset_n,
	input wire logic flag_gate_n,
	input wire ptef_byte_t host_side_port_in,
	output ptef_byte_t host_side_port_out,
	output logic host_side_port_oe,
	input wire ptef_byte_t bus_side_port_in,
	output ptef_byte_t bus_side_port_out,
	output logic bus_side_port_oe,
	input wire logic parity_in,
	output logic parity_out,
	output logic parity_oe,
	input wire logic host_valid,
	output logic host_ready,
	output logic recv_valid,
	input wire logic recv_ready,
	output logic fault_n_out,
	output logic fault_n_oe
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic odd_bit(input ptef_byte_t d);
		odd_bit = ~(^d);
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] rx_n_s, tx_n_s, clr_s, gate_s, par_s;
	ptef_byte_t host_s1, host_s2, bus_s1, bus_s2;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_n_s <= 2'h3;
			tx_n_s <= 2'h3;
			clr_s <= 2'h3;
			gate_s <= 2'h3;
			par_s <= 2'h0;
			host_s1 <= 8'h00;
			host_s2 <= 8'h00;
			bus_s1 <= 8'h00;
			bus_s2 <= 8'h00;
		end else begin
			rx_n_s <= {rx_n_s[0], receive_drive_n};
			tx_n_s <= {tx_n_s[0], transmit_drive_n};
			clr_s <= {clr_s[0], flag_reset_n};
			gate_s <= {gate_s[0], flag_gate_n};
			par_s <= {par_s[0], parity_in};
			host_s1 <= host_side_port_in;
			host_s2 <= host_s1;
			bus_s1 <= bus_side_port_in;
			bus_s2 <= bus_s1;
		end
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	wire rx_n = rx_n_s[1];
	wire tx_n = tx_n_s[1];
	wire clr_n = clr_s[1];
	wire gate_n = gate_s[1];
	ptef_mode_t mode;
	always_comb begin
		case ({tx_n, rx_n})
			2'h2: mode = PTEF_RECEIVE; // RULE1
			2'h1: mode = PTEF_TRANSMIT; // RULE2
			2'h0: mode = PTEF_FORCE; // RULE8
			default: mode = PTEF_ISOLATE; // RULE7
		endcase
	end
	wire is_rx = (mode == PTEF_RECEIVE);
	wire is_tx = (mode == PTEF_TRANSMIT);
	wire is_force = (mode == PTEF_FORCE);
	wire is_iso = (mode == PTEF_ISOLATE);

	// ------------------------------------------------------------
	// Two-entry buffers, one per direction
	// ------------------------------------------------------------
	// A stalled receiver leaves words in the buffer rather than losing them
	ptef_byte_t tx_mem [`PTEF_BUF_DEPTH];
	ptef_byte_t rx_mem [`PTEF_BUF_DEPTH];
	logic [1:0] tx_cnt, rx_cnt;
	logic tx_wp, tx_rp, rx_wp, rx_rp;
	wire tx_push = is_tx & host_valid & (tx_cnt != 2'h2);
	wire tx_pop = (tx_cnt != 2'h0);
	wire rx_push = is_rx & (rx_cnt != 2'h2);
	wire rx_pop = recv_valid & recv_ready;
	assign host_ready = is_tx & (tx_cnt != 2'h2);
	assign recv_valid = (rx_cnt != 2'h0);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_cnt <= 2'h0;
			tx_wp <= 1'b0;
			tx_rp <= 1'b0;
		end else begin
			if (tx_push) begin
				tx_mem[tx_wp] <= host_s2; // RULE3
				tx_wp <= ~tx_wp;
			end
			if (tx_pop)
				tx_rp <= ~tx_rp;
			tx_cnt <= tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_cnt <= 2'h0;
			rx_wp <= 1'b0;
			rx_rp <= 1'b0;
		end else begin
			if (rx_push) begin
				rx_mem[rx_wp] <= bus_s2; // RULE4
				rx_wp <= ~rx_wp;
			end
			if (rx_pop)
				rx_rp <= ~rx_rp;
			rx_cnt <= rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop};
		end
	end

	// ------------------------------------------------------------
	// Data and parity outputs
	// ------------------------------------------------------------
	wire ptef_byte_t next_bus = tx_mem[tx_rp];
	wire next_par_tx = odd_bit(next_bus); // RULE5
	// Forced parity is the wrong bit for the word on the bus
	wire next_par_force = ~odd_bit(bus_s2); // RULE8
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bus_side_port_out <= 8'h00;
			host_side_port_out <= 8'h00;
			parity_out <= 1'b0;
		end else begin
			if (tx_pop) begin
				bus_side_port_out <= next_bus;
				parity_out <= next_par_tx;
			end else if (is_force)
				parity_out <= next_par_force;
			if (rx_pop)
				host_side_port_out <= rx_mem[rx_rp];
		end
	end
	assign bus_side_port_oe = is_tx; // RULE7
	assign host_side_port_oe = is_rx & recv_valid; // RULE7
	assign parity_oe = is_tx | is_force; // RULE7

	// ------------------------------------------------------------
	// Parity check and error flag
	// ------------------------------------------------------------
	// In forced mode the checker sees the driven wrong bit, so it errs
	wire chk_par = is_force ? next_par_force : par_s[1];
	wire chk_err = (is_rx | is_force) & (odd_bit(bus_s2) != chk_par); // RULE6 RULE9
	logic flag;
	logic next_flag;
	always_comb begin
		next_flag = flag;
		if (VARIANT == PTEF_REGISTERED) begin
			next_flag = flag | chk_err; // RULE10 RULE11
		end else if (VARIANT == PTEF_LATCHED_HOLD && is_iso) begin
			next_flag = flag; // RULE17
		end else if (!gate_n) begin
			next_flag = clr_n ? (flag | chk_err) : chk_err; // RULE13 RULE14
		end else begin
			next_flag = clr_n ? flag : 1'b0; // RULE15 RULE16
		end
	end
	// Registered clear acts on the synchronised pin, so it lags by two edges
	wire reg_clear = (VARIANT == PTEF_REGISTERED) & ~clr_n; // RULE12
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			flag <= `PTEF_FLAG_RST;
		else if (reg_clear)
			flag <= 1'b0; // RULE12
		else
			flag <= next_flag; // RULE20
	end
	assign fault_n_out = 1'b0; // RULE18
	assign fault_n_oe = flag; // RULE18 RULE20

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence err_seen_s;
		chk_err && !reg_clear;
	endsequence
	tx_parity_odd_a: assert property (@(posedge clock) disable iff (!reset_n)
		tx_pop |=> (^{bus_side_port_out, parity_out}) == 1'b1) // RULE5
		else $error("transmit parity not odd");
	iso_float_a: assert property (@(posedge clock) disable iff (!reset_n)
		is_iso |-> !bus_side_port_oe && !host_side_port_oe && !parity_oe) // RULE7
		else $error("isolation left a driver on");
	force_err_a: assert property (@(posedge clock) disable iff (!reset_n)
		is_force |-> chk_err) // RULE8
		else $error("forced mode did not report an error");
	flag_sets_a: assert property (@(posedge clock) disable iff (!reset_n)
		(VARIANT == PTEF_REGISTERED) and err_seen_s
		|=> fault_n_oe) // RULE9 RULE11
		else $error("error not flagged");
	flag_sticks_a: assert property (@(posedge clock) disable iff (!reset_n)
		(VARIANT == PTEF_REGISTERED) && flag && clr_n |=> flag) // RULE10
		else $error("flag dropped without clear");
	flag_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
		reg_clear |=> !flag) // RULE12
		else $error("clear did not empty flag");
	latch_store_a: assert property (@(posedge clock) disable iff (!reset_n)
		(VARIANT != PTEF_REGISTERED) && gate_n && clr_n
		|=> flag == $past(flag)) // RULE16
		else $error("store changed flag");
	latch_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
		(VARIANT != PTEF_REGISTERED) && gate_n && !clr_n
		&& !((VARIANT == PTEF_LATCHED_HOLD) && is_iso) |=> !flag) // RULE15
		else $error("latch clear failed");
	tx_mode_drive_a: assert property (@(posedge clock) disable iff (!reset_n)
		!tx_n && rx_n |-> bus_side_port_oe && parity_oe) // RULE2 RULE4
		else $error("transmit mode not driving bus");

	// ------------------------------------------------------------
	// Receive check, latch, buffer, mode, fault and forced parity checks
	// ------------------------------------------------------------
	// Latch steps only count where the hold variant is not frozen
	wire latch_live = (VARIANT != PTEF_REGISTERED)
		&& !((VARIANT == PTEF_LATCHED_HOLD) && is_iso);
	sequence rx_bad_group_s;
		is_rx && (^{bus_s2, par_s[1]} == 1'b0);
	endsequence
	sequence rx_good_group_s;
		is_rx && (^{bus_s2, par_s[1]} == 1'b1);
	endsequence
	sequence pass_step_s;
		latch_live && !gate_n && !clr_n;
	endsequence
	sequence sample_step_s;
		latch_live && !gate_n && clr_n && flag;
	endsequence
	// A clear followed by store must leave the flag empty
	sequence clear_then_store_s;
		(latch_live && gate_n && !clr_n) ##1 (latch_live && gate_n && clr_n);
	endsequence

	rx_bad_err_a: assert property (@(posedge clock) // RULE6 RULE9
		disable iff (!reset_n)
		rx_bad_group_s |-> chk_err)
		else $error("even receive group not flagged");
	rx_good_ok_a: assert property (@(posedge clock) // RULE6
		disable iff (!reset_n)
		rx_good_group_s |-> !chk_err)
		else $error("odd receive group flagged");
	latch_pass_a: assert property (@(posedge clock) // RULE14
		disable iff (!reset_n)
		pass_step_s |=> flag == $past(chk_err))
		else $error("pass mode did not follow check");
	latch_sample_a: assert property (@(posedge clock) // RULE13 RULE14
		disable iff (!reset_n)
		sample_step_s |=> flag)
		else $error("sampled error dropped");
	latch_cleared_a: assert property (@(posedge clock) // RULE15 RULE16
		disable iff (!reset_n)
		clear_then_store_s |=> !flag)
		else $error("store after clear not empty");
	hold_iso_a: assert property (@(posedge clock) // RULE17
		disable iff (!reset_n)
		(VARIANT == PTEF_LATCHED_HOLD) && is_iso |=> flag == $past(flag))
		else $error("hold variant changed flag in isolation");
	rx_mode_drive_a: assert property (@(posedge clock) // RULE1
		disable iff (!reset_n)
		is_rx |-> !bus_side_port_oe && !parity_oe)
		else $error("receive mode drives bus side");
	host_ready_mode_a: assert property (@(posedge clock) // RULE2
		disable iff (!reset_n)
		host_ready |-> is_tx)
		else $error("host word taken outside transmit");
	rx_push_mode_a: assert property (@(posedge clock) // RULE1 RULE4
		disable iff (!reset_n)
		rx_push |-> is_rx)
		else $error("bus word taken outside receive");
	rx_hold_a: assert property (@(posedge clock) // RULE3
		disable iff (!reset_n)
		recv_valid && !recv_ready |=> $stable(host_side_port_out))
		else $error("host word changed during stall");
	tx_word_a: assert property (@(posedge clock) // RULE4
		disable iff (!reset_n)
		tx_pop |=> bus_side_port_out == $past(next_bus))
		else $error("bus word not the buffered word");
	buf_bound_a: assert property (@(posedge clock) // RULE3 RULE4
		disable iff (!reset_n)
		tx_cnt != 2'h3 && rx_cnt != 2'h3)
		else $error("buffer count out of range");
	fault_drive_a: assert property (@(posedge clock) // RULE18 RULE20
		disable iff (!reset_n)
		fault_n_oe |-> !fault_n_out)
		else $error("fault line not pulled low");
	reg_load_a: assert property (@(posedge clock) // RULE11
		disable iff (!reset_n)
		(VARIANT == PTEF_REGISTERED) && !flag && !chk_err |=> !flag)
		else $error("flag set without error");
	force_par_a: assert property (@(posedge clock) // RULE8
		disable iff (!reset_n)
		is_force && !tx_pop |=> parity_out == $past(next_par_force))
		else $error("forced parity not the wrong bit");
	iso_ready_a: assert property (@(posedge clock) // RULE7
		disable iff (!reset_n)
		is_iso |-> !host_ready && !host_side_port_oe)
		else $error("isolation still accepts or drives");

endmodule // ptef_transceiver

//--- tb/ptef_bus_model.sv
// ------------------------------------------------
// Far side of the bus port and parity line
// ------------------------------------------------
module ptef_bus_model
	import ptef_pkg::*;
(
	input wire logic clock,
	input wire logic drive,
	input wire ptef_byte_t word,
	input wire logic bad,
	output ptef_byte_t bus,
	output logic parity
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		bus = 8'h00;
		parity = 1'b1;
	end
	// Released lines keep toggling so a stale value never looks valid
	always @(posedge clock) begin
		if (drive) begin
			bus <= word;
			parity <= (~^word) ^ bad;
		end else begin
			bus <= ~bus;
			parity <= ~parity;
		end
	end
endmodule // ptef_bus_model

//--- tb/testbench.sv
module testbench;
	import ptef_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, reset_n, receive_drive_n, transmit_drive_n, flag_reset_n;
	logic flag_gate_n, host_valid, recv_ready, bad, par_m, parity_in;
	logic host_oe, bus_oe, parity_out, parity_oe, host_ready, recv_valid;
	logic fault_n_out, fault_n_oe, latch_oe;
	ptef_byte_t host_in, host_w, host_out, bus_m, bus_w, bus_out, word;
	int failures, tests_run, cycles;
	logic [31:0] seed;
	assign bus_w = bus_oe ? bus_out : bus_m;
	assign parity_in = parity_oe ? parity_out : par_m;
	assign host_w = host_oe ? host_out : host_in;
	ptef_bus_model far (.clock(clock), .word(word), .bad(bad), .bus(bus_m),
		.drive(transmit_drive_n | ~receive_drive_n), .parity(par_m));
	ptef_transceiver uut (.clock(clock), .reset_n(reset_n),
		.receive_drive_n(receive_drive_n), .transmit_drive_n(transmit_drive_n),
		.flag_reset_n(flag_reset_n), .flag_gate_n(flag_gate_n),
		.host_side_port_in(host_w), .host_side_port_out(host_out),
		.host_side_port_oe(host_oe), .bus_side_port_in(bus_w),
		.bus_side_port_out(bus_out), .bus_side_port_oe(bus_oe),
		.parity_in(parity_in), .parity_out(parity_out), .parity_oe(parity_oe),
		.host_valid(host_valid), .host_ready(host_ready),
		.recv_valid(recv_valid), .recv_ready(recv_ready),
		.fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe));
	ptef_transceiver #(.VARIANT(PTEF_LATCHED_HOLD)) uut_latch (
		.clock(clock), .reset_n(reset_n),
		.receive_drive_n(receive_drive_n), .transmit_drive_n(transmit_drive_n),
		.flag_reset_n(flag_reset_n), .flag_gate_n(flag_gate_n),
		.host_side_port_in(host_w), .host_side_port_out(),
		.host_side_port_oe(), .bus_side_port_in(bus_w),
		.bus_side_port_out(), .bus_side_port_oe(),
		.parity_in(parity_in), .parity_out(), .parity_oe(),
		.host_valid(host_valid), .host_ready(),
		.recv_valid(), .recv_ready(recv_ready),
		.fault_n_out(), .fault_n_oe(latch_oe));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic settle;
		repeat (6) @(negedge clock);
	endtask
	task automatic mode(input logic t, input logic r);
		transmit_drive_n = t;
		receive_drive_n = r;
		settle();
	endtask
	// Data is held before valid rises since the host port is synchronised
	task automatic send(input ptef_byte_t d);
		int n;
		n = 0;
		host_in = d;
		repeat (3) @(negedge clock);
		host_valid = 1'b1;
		while (host_ready !== 1'b1 && n < 20) begin
			@(negedge clock);
			n++;
		end
		chk(host_ready, 1'b1);
		@(negedge clock);
		host_valid = 1'b0;
	endtask
	task automatic end_sim;
		$display("Counts: %0d checks, %0d mismatches", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			$display("[ERR] %0t run did not finish", $time);
			end_sim();
		end
	end
	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		{reset_n, host_valid, recv_ready, bad} = 4'h0;
		{receive_drive_n, transmit_drive_n, flag_reset_n, flag_gate_n} = 4'hF;
		{host_in, word} = 16'h0000;
		seed = 32'h0000000E;
		repeat (6) @(negedge clock);
		reset_n = 1'b1;
		settle();
		mode(1'b0, 1'b1);
		chk({bus_oe, parity_oe, host_oe}, 8'h06);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			send(i == 0 ? 8'h00 : i == 1 ? 8'hFF : seed[7:0]);
			settle();
			chk(bus_out, host_in);
			chk(parity_out, ~^host_in);
		end
		$display("Test transmit done");
		recv_ready = 1'b1;
		mode(1'b1, 1'b0);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			word = seed[7:0];
			settle();
			chk({host_oe, bus_oe, parity_oe}, 8'h04);
			chk(host_out, word);
			chk(fault_n_oe, 1'b0);
		end
		bad = 1'b1;
		flag_gate_n = 1'b0;
		settle();
		chk({fault_n_oe, fault_n_out}, 8'h02);
		chk(latch_oe, 1'b1);
		bad = 1'b0;
		settle();
		chk(fault_n_oe, 1'b1);
		chk(latch_oe, 1'b1);
		flag_gate_n = 1'b1;
		settle();
		chk(latch_oe, 1'b1);
		flag_reset_n = 1'b0;
		settle();
		chk(fault_n_oe, 1'b0);
		chk(latch_oe, 1'b0);
		flag_reset_n = 1'b1;
		$display("Test receive and flag done");
		recv_ready = 1'b0;
		word = ~word;
		settle();
		chk(host_out, ~word);
		chk(recv_valid, 1'b1);
		recv_ready = 1'b1;
		settle();
		chk(host_out, word);
		$display("Test stall done");
		mode(1'b1, 1'b1);
		chk({host_oe, bus_oe, parity_oe, recv_valid, host_ready}, 8'h00);
		chk(latch_oe, 1'b0);
		mode(1'b0, 1'b0);
		chk(parity_oe, 1'b1);
		chk(parity_out, ^word);
		chk(fault_n_oe, 1'b1);
		chk(latch_oe, 1'b0);
		$display("Test isolate and forced error done");
		end_sim();
	end
endmodule // testbench
